// file: hw/lsc_map.vh
`ifndef LSC_MAP_VH
`define LSC_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LSC_A_CTRL     4'h0
`define LSC_A_CFG      4'h1
`define LSC_A_CMD      4'h2
`define LSC_A_TXF      4'h3
`define LSC_A_RXF      4'h4
`define LSC_A_STAT     4'h5
`define LSC_A_AHI      4'h6
`define LSC_A_ALO      4'h7
`define LSC_A_PRE      4'h8
// ----------------------------------------
// Control and configuration fields
// ----------------------------------------
`define LSC_K_TRN      0
`define LSC_K_SHF      1
`define LSC_K_TCD      2
`define LSC_K_RFW      3
`define LSC_K_MSG      4
`define LSC_K_FLT      5
`define LSC_K_PRE      6
`define LSC_K_AM       7
`define LSC_K_IDF      9
`define LSC_G_E1       0
`define LSC_G_SA       1
`define LSC_G_PC       6
// ----------------------------------------
// Command bits
// ----------------------------------------
`define LSC_C_START_HDLC 0
`define LSC_C_START_TRN  1
`define LSC_C_MSG_END    2
`define LSC_C_ABORT      3
`define LSC_C_SOFTRST    4
`define LSC_C_REPEAT     5
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define LSC_RST_CTRL   16'h0000
`define LSC_RST_CFG    16'h0000
`define LSC_RST_PRE    8'h00
`define LSC_FLAG       8'h7E
`define LSC_ONES       8'hFF
`define LSC_CRC_INIT   16'hFFFF
`define LSC_CRC_POLY   16'h8408
`define LSC_CRC_GOOD   16'hF0B8
`define LSC_TY_HDLC    2'h2
`define LSC_TY_MSG     2'h1
`define LSC_S_VALID    5'h00
`define LSC_S_OVF      5'h01
`define LSC_S_ABORT    5'h02
`define LSC_S_NONOCT   5'h03
`define LSC_S_CRCERR   5'h04
`define LSC_S_FILT     5'h00
`define LSC_S_MEND     5'h02
// ----------------------------------------
// Bit and pattern counts
// ----------------------------------------
`define LSC_STUFF_RUN  3'h5
`define LSC_ABORT_RUN  4'h7
`define LSC_MSG_RUN    4'h8
`define LSC_SYNC_LAST  5'h1F
`define LSC_FLT_HIT    4'h7
`define LSC_FLT_WIN    4'hA
`define LSC_FLT_EXIT   3'h4
`endif

// file: hw/lsc_crc16.v
`include "lsc_map.vh"
// ----------------------------------------
// Byte-wide checksum step, LSB first
// ----------------------------------------
module lsc_crc16 (
  input  wire [15:0] crc_in,
  input  wire [7:0]  data,
  output reg  [15:0] crc_out
);
  integer    i;
  reg [15:0] c;
  always @*
  begin
    c = crc_in;
    for (i = 0; i < 8; i = i + 1)
      c = (c[0] ^ data[i]) ? ({1'b0, c[15:1]} ^ `LSC_CRC_POLY) : {1'b0, c[15:1]};
    crc_out = c;
  end
endmodule // lsc_crc16

// file: hw/lsc_link_ctrl.v
// Notes on behaviour
// - HDLC transmit makes flags, checksum, stuffing zeros and idle code.
// - Transmit bytes wait in a two-page, 32-byte-per-page FIFO.
// - Bits use T1 data-link slots or software-chosen E1 spare bits.
// - Shared flag: closing flag opens the next waiting frame.
// - Last two bytes are the checksum, always checked, optionally stored.
// - Checksum disable sends last two FIFO bytes as checksum, then flag.
// - Frame length from software is never checked.
// - Address compare passes matching frames, drops the rest.
// - Two-byte address: two high and two low values; one-byte: low only.
// - Stored frame is control, information bytes and one status byte.
// - Preamble pattern sent a set number of times, no stuffing.
// - Transparent mode moves raw bytes, no flags, checksum or stuffing.
// - Repeat sends the loaded 1 to 64 bytes cyclically.
// - Soft reset or repeat cleared stops cycling; ones follow.
// - Eight ones enter message mode; a flag returns to HDLC.
// - No eight-ones run in 32 bits raises bad sync event.
// - Regular mode syncs on all-ones, keeps bytes with zero ends.
// - Flag in message mode stores message status, raises message end.
// - Disabling message receiver stores status, raises end, back to HDLC.
// - Filter mode stores a pattern seen 7 times in 10.
// - Filter exits on 4 differing patterns, 4 idle patterns or flag.
// - Status byte: type field, overflow bit (always zero in HDLC status, which reports overflow as a code), five-bit code.
// - Empty FIFO before message end aborts frame, raises underrun.
`include "lsc_map.vh"
module lsc_link_ctrl #(
  parameter AW = 6
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        tx_slot,
  input  wire [2:0]  tx_slot_sa,
  input  wire        tx_slot_dl,
  output reg         tx_bit,
  output reg         tx_bit_valid,
  input  wire        rx_slot,
  input  wire [2:0]  rx_slot_sa,
  input  wire        rx_slot_dl,
  input  wire        rx_bit
);
  localparam DEPTH = 1 << AW;
  localparam [AW:0] FULL = {1'b1, {AW{1'b0}}};
  localparam [AW:0] PAGE = {2'b01, {(AW - 1){1'b0}}};
  localparam [2:0] T_IDLE = 3'h0, T_PRE = 3'h1, T_OPEN = 3'h2, T_DATA = 3'h3;
  localparam [2:0] T_CRCL = 3'h4, T_CRCH = 3'h5, T_CLOSE = 3'h6, T_TRN = 3'h7;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  reg  [15:0] ctrl_r, cfg_r, ahi_r, alo_r;
  reg  [7:0]  pre_r;
  reg         rep_r;
  reg  [2:0]  ev_r;
  wire        cmd_w   = reg_wr && reg_addr == `LSC_A_CMD;
  wire        softrst = cmd_w && reg_wdata[`LSC_C_SOFTRST];
  wire        tr      = ctrl_r[`LSC_K_TRN];
  wire        msg_en  = ctrl_r[`LSC_K_MSG];
  wire [1:0]  alen    = ctrl_r[`LSC_K_AM+1:`LSC_K_AM];
  wire [7:0]  sa_ext  = {3'h0, cfg_r[`LSC_G_SA+4:`LSC_G_SA]};
  wire        stat_rd = reg_rd && reg_addr == `LSC_A_STAT;
  wire        rd_rxf  = reg_rd && reg_addr == `LSC_A_RXF;

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_r <= `LSC_RST_CTRL;
      cfg_r  <= `LSC_RST_CFG;
      ahi_r  <= 16'h0000;
      alo_r  <= 16'h0000;
      pre_r  <= `LSC_RST_PRE;
      rep_r  <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `LSC_A_CTRL)
        ctrl_r <= reg_wdata;
      if (reg_wr && reg_addr == `LSC_A_CFG)
        cfg_r <= reg_wdata;
      if (reg_wr && reg_addr == `LSC_A_AHI)
        ahi_r <= reg_wdata;
      if (reg_wr && reg_addr == `LSC_A_ALO)
        alo_r <= reg_wdata;
      if (reg_wr && reg_addr == `LSC_A_PRE)
        pre_r <= reg_wdata[7:0];
      if (softrst)
        rep_r <= 1'b0;
      else if (cmd_w)
        rep_r <= reg_wdata[`LSC_C_REPEAT];
    end
  end

  // ----------------------------------------
  // Transmit FIFO and serialiser
  // ----------------------------------------
  reg  [7:0]  txm [0:DEPTH-1];
  reg  [AW:0] txw_r, txr_r, txb_r;
  reg  [2:0]  ts_r, tones_r;
  reg  [7:0]  tsh_r;
  reg  [3:0]  tbc_r, tpre_r;
  reg  [15:0] tcrc_r;
  reg         tgo_r, tend_r, tab_r, ttrn_r, trep_r, tx_underrun_event;
  reg  [2:0]  n_st;
  reg  [7:0]  n_by;
  reg         pop, rew, flush, cinit, done, under;
  wire [15:0] tcrc_n;
  wire [AW:0] tx_cnt  = txw_r - txr_r;
  wire        tx_has  = tx_cnt != {(AW + 1){1'b0}};
  wire        txf_psh = reg_wr && reg_addr == `LSC_A_TXF && tx_cnt != FULL;
  wire [7:0]  tx_head = txm[txr_r[AW-1:0]];
  wire [7:0]  idle_by = (ctrl_r[`LSC_K_IDF] && !tr) ? `LSC_FLAG : `LSC_ONES;
  wire        stf     = (ts_r == T_DATA || ts_r == T_CRCL || ts_r == T_CRCH);
  wire        tx_take = tx_slot && (cfg_r[`LSC_G_E1] ? sa_ext[tx_slot_sa] : tx_slot_dl);

  lsc_crc16 u_tcrc (
    .crc_in  (cinit ? `LSC_CRC_INIT : tcrc_r),
    .data    (n_by),
    .crc_out (tcrc_n)
  );

  always @(posedge clk)
    if (txf_psh)
      txm[txw_r[AW-1:0]] <= reg_wdata[7:0];

  // Next byte once the current one is out
  always @*
  begin
    n_st  = ts_r;
    n_by  = `LSC_ONES;
    pop   = 1'b0;
    rew   = 1'b0;
    flush = 1'b0;
    cinit = 1'b0;
    done  = 1'b0;
    under = 1'b0;
    case (ts_r)
      T_IDLE, T_CLOSE:
      begin
        n_st = T_IDLE;
        n_by = idle_by;
        if (tgo_r && tx_has)
        begin
          if (ttrn_r)
          begin
            n_st = T_TRN;
            n_by = tx_head;
            pop  = 1'b1;
          end
          else if (ts_r == T_CLOSE && ctrl_r[`LSC_K_SHF])
          begin
            n_st  = T_DATA;
            n_by  = tx_head;
            pop   = 1'b1;
            cinit = 1'b1;
          end
          else if (ctrl_r[`LSC_K_PRE])
          begin
            n_st = T_PRE;
            n_by = pre_r;
          end
          else
          begin
            n_st = T_OPEN;
            n_by = `LSC_FLAG;
          end
        end
      end
      T_PRE:
      begin
        n_by = (tpre_r == 4'h0) ? `LSC_FLAG : pre_r;
        n_st = (tpre_r == 4'h0) ? T_OPEN : T_PRE;
      end
      T_OPEN:
      begin
        n_st  = T_DATA;
        n_by  = tx_head;
        pop   = tx_has;
        cinit = 1'b1;
        under = !tx_has;
      end
      T_DATA:
      begin
        n_by = tx_head;
        pop  = tx_has;
        if (!tx_has && tend_r && ctrl_r[`LSC_K_TCD])
        begin
          n_st = T_CLOSE;
          n_by = `LSC_FLAG;
          done = 1'b1;
        end
        else if (!tx_has && tend_r)
        begin
          n_st = T_CRCL;
          n_by = ~tcrc_r[7:0];
        end
        else if (!tx_has)
          under = 1'b1;
      end
      T_CRCL:
      begin
        n_st = T_CRCH;
        n_by = ~tcrc_r[15:8];
      end
      T_CRCH:
      begin
        n_st = T_CLOSE;
        n_by = `LSC_FLAG;
        done = 1'b1;
      end
      T_TRN:
      begin
        if (trep_r && !rep_r)
        begin
          n_st  = T_IDLE;
          flush = 1'b1;
          done  = 1'b1;
        end
        else if (tx_has)
        begin
          n_by = tx_head;
          pop  = 1'b1;
        end
        else if (trep_r && txb_r != txw_r)
        begin
          n_by = txm[txb_r[AW-1:0]];
          rew  = 1'b1;
        end
        else
        begin
          n_st = T_IDLE;
          done = 1'b1;
        end
      end
      default:
        n_st = T_IDLE;
    endcase
    if ((under || tab_r) && stf)
    begin
      n_st  = T_IDLE;
      n_by  = `LSC_ONES;
      pop   = 1'b0;
      done  = 1'b1;
      under = 1'b1;
    end
  end

  always @(posedge clk)
  begin
    if (!nrst || softrst)
    begin
      ts_r <= T_IDLE;
      tsh_r <= `LSC_ONES;
      tbc_r <= 4'h8;
      tones_r <= 3'h0;
      tcrc_r <= `LSC_CRC_INIT;
      tpre_r <= 4'h0;
      {tgo_r, tend_r, tab_r, ttrn_r, trep_r} <= 5'h00;
      txw_r <= {(AW + 1){1'b0}};
      txr_r <= {(AW + 1){1'b0}};
      txb_r <= {(AW + 1){1'b0}};
      tx_bit <= 1'b1;
      tx_bit_valid <= 1'b0;
      tx_underrun_event <= 1'b0;
    end
    else
    begin
      tx_bit_valid <= tx_take;
      tx_underrun_event <= 1'b0;
      if (txf_psh)
        txw_r <= txw_r + 1'b1;
      if (tx_take && tones_r == `LSC_STUFF_RUN)
      begin
        tx_bit  <= 1'b0;
        tones_r <= 3'h0;
      end
      else if (tx_take)
      begin
        tx_bit  <= tsh_r[0];
        tones_r <= (stf && !ttrn_r && tsh_r[0]) ? tones_r + 3'h1 : 3'h0;
        if (tbc_r == 4'h1)
        begin
          ts_r  <= n_st;
          tsh_r <= n_by;
          tbc_r <= 4'h8;
          if (pop && n_st == T_DATA)
            tcrc_r <= tcrc_n;
          if (ts_r != T_PRE)
            tpre_r <= cfg_r[`LSC_G_PC+3:`LSC_G_PC];
          else
            tpre_r <= tpre_r - 4'h1;
          if (ts_r != T_TRN && n_st == T_TRN)
          begin
            txb_r  <= txr_r;
            trep_r <= rep_r;
          end
          if (pop)
            txr_r <= txr_r + 1'b1;
          else if (rew)
            txr_r <= txb_r + 1'b1;
          else if (flush)
            txr_r <= txw_r;
          if (done)
            {tgo_r, tend_r, tab_r} <= 3'h0;
          tx_underrun_event <= under && !tab_r;
        end
        else
        begin
          tsh_r <= {1'b1, tsh_r[7:1]};
          tbc_r <= tbc_r - 4'h1;
        end
      end
      if (cmd_w && (reg_wdata[`LSC_C_START_HDLC] || reg_wdata[`LSC_C_START_TRN]))
      begin
        tgo_r  <= 1'b1;
        ttrn_r <= reg_wdata[`LSC_C_START_TRN];
      end
      if (cmd_w && reg_wdata[`LSC_C_MSG_END])
        tend_r <= 1'b1;
      if (cmd_w && reg_wdata[`LSC_C_ABORT])
        tab_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Receive deframer and FIFO
  // ----------------------------------------
  reg  [7:0]  rxm [0:DEPTH-1];
  reg  [AW:0] rxw_r, rxr_r;
  reg  [7:0]  rh_r, rby_r, rd1_r, rd2_r, mb_r, fcand_r, facc_r, q0_r, q1_r, q2_r;
  reg  [3:0]  rones_r, fmat_r, fwin_r;
  reg  [2:0]  rbc_r, mbc_r, fdif_r, fidl_r;
  reg  [1:0]  ridx_r, rnd_r, qn_r;
  reg  [4:0]  msc_r;
  reg  [15:0] rcrc_r;
  reg         rin_r, rmsg_r, rovf_r, hok_r, lok_r, msy_r, fdec_r;
  reg         rx_message_end_event, bad_sync_format_event;
  wire [15:0] rcrc_n;
  wire [AW:0] rx_cnt  = rxw_r - rxr_r;
  wire        rx_full = rx_cnt == FULL;
  wire        rx_take = rx_slot && (cfg_r[`LSC_G_E1] ? sa_ext[rx_slot_sa] : rx_slot_dl);
  wire [7:0]  rh_n    = {rx_bit, rh_r[7:1]};
  wire [7:0]  rb_n    = {rx_bit, rby_r[7:1]};
  wire [7:0]  mb_n    = {rx_bit, mb_r[7:1]};
  wire [3:0]  r1      = !rx_bit ? 4'h0 : (rones_r == 4'hF) ? 4'hF : rones_r + 4'h1;
  wire        acc     = alen == 2'h0 || (alen == 2'h1 ? lok_r : hok_r && lok_r);
  wire        mvalid  = !mb_n[0] && !mb_n[7];
  wire [4:0]  hcode   = rovf_r ? `LSC_S_OVF : (rbc_r != 3'h7) ? `LSC_S_NONOCT :
                        (rcrc_r != `LSC_CRC_GOOD) ? `LSC_S_CRCERR : `LSC_S_VALID;
  wire [7:0]  hst     = {`LSC_TY_HDLC, 1'b0, hcode};
  wire [7:0]  mst     = {`LSC_TY_MSG, rovf_r, `LSC_S_MEND};
  wire        lo_hit  = rb_n == alo_r[7:0] || rb_n == alo_r[15:8];
  wire        hi_hit  = rb_n == ahi_r[7:0] || rb_n == ahi_r[15:8];

  lsc_crc16 u_rcrc (
    .crc_in  (rcrc_r),
    .data    (rb_n),
    .crc_out (rcrc_n)
  );

  always @(posedge clk)
    if (qn_r != 2'h0 && !rx_full)
      rxm[rxw_r[AW-1:0]] <= q0_r;

  always @(posedge clk)
  begin
    if (!nrst || softrst)
    begin
      {rxw_r, rxr_r} <= {(2 * AW + 2){1'b0}};
      {rh_r, rby_r, rd1_r, rd2_r, mb_r} <= 40'h0;
      {fcand_r, facc_r, q0_r, q1_r, q2_r} <= 40'h0;
      {rones_r, fmat_r, fwin_r, rbc_r, mbc_r, fdif_r, fidl_r} <= 24'h0;
      {ridx_r, rnd_r, qn_r, msc_r} <= 11'h000;
      rcrc_r <= `LSC_CRC_INIT;
      {rin_r, rmsg_r, rovf_r, hok_r, lok_r, msy_r, fdec_r} <= 7'h00;
      {rx_message_end_event, bad_sync_format_event} <= 2'h0;
    end
    else
    begin
      {rx_message_end_event, bad_sync_format_event} <= 2'h0;
      if (qn_r != 2'h0)
      begin
        if (!rx_full)
          rxw_r <= rxw_r + 1'b1;
        else
          rovf_r <= 1'b1;
        q0_r <= q1_r;
        q1_r <= q2_r;
        qn_r <= qn_r - 2'h1;
      end
      if (rd_rxf && rx_cnt != {(AW + 1){1'b0}})
        rxr_r <= rxr_r + 1'b1;
      if (rmsg_r && !msg_en)
      begin
        q0_r <= mst;
        qn_r <= 2'h1;
        rx_message_end_event <= 1'b1;
        rmsg_r <= 1'b0;
      end
      else if (rx_take)
      begin
        rh_r <= rh_n;
        rones_r <= r1;
        if (tr)
        begin
          rby_r <= rb_n;
          rbc_r <= rbc_r + 3'h1;
          if (rbc_r == 3'h7)
          begin
            q0_r <= rb_n;
            qn_r <= 2'h1;
          end
        end
        else if (rh_n == `LSC_FLAG)
        begin
          if (rmsg_r)
          begin
            q0_r <= mst;
            qn_r <= 2'h1;
            rx_message_end_event <= 1'b1;
          end
          else if (rin_r && ridx_r != 2'h0 && acc)
          begin
            q0_r <= ctrl_r[`LSC_K_RFW] ? rd2_r : hst;
            q1_r <= rd1_r;
            q2_r <= hst;
            qn_r <= ctrl_r[`LSC_K_RFW] ? 2'h3 : 2'h1;
            rx_message_end_event <= 1'b1;
          end
          {rmsg_r, rin_r, hok_r, lok_r, rovf_r} <= 5'h08;
          {ridx_r, rnd_r, rbc_r} <= 7'h00;
          rcrc_r <= `LSC_CRC_INIT;
        end
        else if (rmsg_r)
        begin
          msc_r <= (r1 >= `LSC_MSG_RUN) ? 5'h00 : msc_r + 5'h01;
          if (r1 < `LSC_MSG_RUN && msc_r == `LSC_SYNC_LAST)
            bad_sync_format_event <= 1'b1;
          if (!msy_r)
            msy_r <= rh_n == `LSC_ONES;
          else
          begin
            mb_r <= mb_n;
            mbc_r <= mbc_r + 3'h1;
            if (mbc_r == 3'h7)
            begin
              msy_r <= 1'b0;
              if (!ctrl_r[`LSC_K_FLT] && mvalid)
              begin
                q0_r <= mb_n;
                qn_r <= 2'h1;
              end
              else if (ctrl_r[`LSC_K_FLT])
              begin
                fidl_r <= (mb_n == `LSC_ONES) ? fidl_r + 3'h1 : 3'h0;
                if (mvalid)
                begin
                  fwin_r <= (fwin_r == `LSC_FLT_WIN - 4'h1) ? 4'h0 : fwin_r + 4'h1;
                  fdif_r <= (fdec_r && mb_n != facc_r) ? fdif_r + 3'h1 : 3'h0;
                  if (fwin_r == 4'h0)
                  begin
                    fcand_r <= mb_n;
                    fmat_r <= 4'h1;
                  end
                  else if (mb_n == fcand_r)
                  begin
                    fmat_r <= fmat_r + 4'h1;
                    if (fmat_r == `LSC_FLT_HIT - 4'h1 && !(fdec_r && facc_r == mb_n))
                    begin
                      q0_r <= mb_n;
                      q1_r <= {`LSC_TY_MSG, rovf_r, `LSC_S_FILT};
                      qn_r <= 2'h2;
                      fdec_r <= 1'b1;
                      facc_r <= mb_n;
                    end
                  end
                end
                if ((mb_n == `LSC_ONES && fidl_r == `LSC_FLT_EXIT - 3'h1) ||
                    (mvalid && fdec_r && mb_n != facc_r && fdif_r == `LSC_FLT_EXIT - 3'h1))
                begin
                  q0_r <= mst;
                  qn_r <= 2'h1;
                  rx_message_end_event <= 1'b1;
                  rmsg_r <= 1'b0;
                end
              end
            end
          end
        end
        else if (msg_en && r1 >= `LSC_MSG_RUN)
        begin
          {rmsg_r, msy_r, rin_r, rovf_r, fdec_r} <= 5'h18;
          {mbc_r, msc_r, fwin_r, fdif_r, fidl_r} <= 18'h00000;
        end
        else if (r1 == `LSC_ABORT_RUN && rin_r)
        begin
          if (ridx_r != 2'h0 && acc)
          begin
            q0_r <= {`LSC_TY_HDLC, 1'b0, `LSC_S_ABORT};
            qn_r <= 2'h1;
            rx_message_end_event <= 1'b1;
          end
          rin_r <= 1'b0;
        end
        else if (rin_r && !(rones_r == {1'b0, `LSC_STUFF_RUN} && !rx_bit))
        begin
          rby_r <= rb_n;
          rbc_r <= rbc_r + 3'h1;
          if (rbc_r == 3'h7)
          begin
            rcrc_r <= rcrc_n;
            if (ridx_r == 2'h0 && alen == 2'h2)
              hok_r <= hi_hit;
            else if (ridx_r < alen)
              lok_r <= lo_hit;
            else
            begin
              if (rnd_r == 2'h2 && acc)
              begin
                q0_r <= rd2_r;
                qn_r <= 2'h1;
              end
              rd2_r <= rd1_r;
              rd1_r <= rb_n;
              if (rnd_r != 2'h2)
                rnd_r <= rnd_r + 2'h1;
            end
            if (ridx_r != 2'h3)
              ridx_r <= ridx_r + 2'h1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Events and read data
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!nrst)
      ev_r <= 3'h0;
    else
      ev_r <= (stat_rd ? 3'h0 : ev_r) |
              {bad_sync_format_event, tx_underrun_event, rx_message_end_event};
  end

  always @(posedge clk)
  begin
    if (!nrst || !reg_rd)
      reg_rdata <= 16'h0000;
    else
      case (reg_addr)
        `LSC_A_CTRL: reg_rdata <= ctrl_r;
        `LSC_A_CFG:  reg_rdata <= cfg_r;
        `LSC_A_CMD:  reg_rdata <= {10'h000, rep_r, 5'h00};
        `LSC_A_RXF:  reg_rdata <= {8'h00, rx_cnt != {(AW + 1){1'b0}} ? rxm[rxr_r[AW-1:0]] : 8'h00};
        `LSC_A_STAT: reg_rdata <= {{(7 - AW){1'b0}}, rx_cnt, 1'b0, rin_r, rmsg_r,
                                   ts_r != T_IDLE || tgo_r, tx_cnt <= PAGE, ev_r};
        `LSC_A_AHI:  reg_rdata <= ahi_r;
        `LSC_A_ALO:  reg_rdata <= alo_r;
        `LSC_A_PRE:  reg_rdata <= {8'h00, pre_r};
        default:     reg_rdata <= 16'h0000;
      endcase
  end
endmodule // lsc_link_ctrl

// file: tb/lsc_link_checker.sv
module lsc_link_checker (
  input logic        clk,
  input logic        nrst,
  input logic [3:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic        tx_slot,
  input logic [2:0]  tx_slot_sa,
  input logic        tx_slot_dl,
  input logic        tx_bit,
  input logic        tx_bit_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cfg_r;
  logic       sel;
  logic       srst;
  assign srst = reg_wr && reg_addr == 4'h2 && reg_wdata[4];
  assign sel  = cfg_r[0] ? |(cfg_r[5:1] & (5'h01 << tx_slot_sa)) : tx_slot_dl;
  always @(posedge clk)
    cfg_r <= !nrst ? 6'h00 : (reg_wr && reg_addr == 4'h1) ? reg_wdata[5:0] : cfg_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_ctrl_back;
    reg_wr && reg_addr == 4'h0 ##2 reg_rd && reg_addr == 4'h0;
  endsequence
  sequence s_srst_stat;
    srst ##2 reg_rd && reg_addr == 4'h5;
  endsequence
  a_slot_answered: assert property (tx_slot && sel && !srst |=> tx_bit_valid)
    else $error("slot not answered");
  a_unsel_quiet: assert property (!(tx_slot && sel) |=> !tx_bit_valid)
    else $error("bit without slot");
  a_bit_holds: assert property (!tx_bit_valid |-> $stable(tx_bit) || $past(srst) && tx_bit)
    else $error("bit moved");
  a_reset_ones: assert property (disable iff (1'b0) !nrst |=> tx_bit && !tx_bit_valid)
    else $error("reset line not ones");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 16'h0000)
    else $error("unmapped read");
  a_ctrl_back: assert property (s_ctrl_back |=> ((reg_rdata ^ $past(reg_wdata, 3)) & 16'h03FF) == 16'h0000)
    else $error("control readback");
  a_srst_empty: assert property (s_srst_stat |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[4])
    else $error("soft reset left data");
endmodule // lsc_link_checker

bind lsc_link_ctrl lsc_link_checker chk_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_slot(tx_slot), .tx_slot_sa(tx_slot_sa), .tx_slot_dl(tx_slot_dl), .tx_bit(tx_bit),
  .tx_bit_valid(tx_bit_valid));

// file: tb/lsc_framer_model.sv
module lsc_framer_model (
  input  logic clk,
  input  logic nrst,
  input  logic tx_bit,
  input  logic tx_bit_valid,
  output logic tx_slot,
  output logic rx_slot,
  output logic rx_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r;
  // Remote loop: each sent bit returns as a receive slot
  always @(posedge clk)
  begin
    cnt_r   <= nrst ? cnt_r + 3'h1 : 3'h0;
    tx_slot <= nrst && cnt_r == 3'h7;
    rx_slot <= nrst && tx_bit_valid;
    rx_bit  <= tx_bit_valid ? tx_bit : !rx_bit;
  end
endmodule // lsc_framer_model

// file: tb/lsc_link_ctrl_tb.sv
module lsc_link_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        mon_on = 1'b0;
  logic        bt = 1'b1;
  logic [2:0]  sa = 3'h0;
  logic [15:0] reg_rdata, d;
  logic        tx_slot, tx_bit, tx_bit_valid, rx_slot, rx_bit;
  logic [7:0]  exp_q[$];
  logic [3:0]  ra[5] = '{4'h0, 4'h1, 4'h8, 4'hF, 4'h5};
  int          num_errors = 0;
  int          checks = 0;
  int          run = 0;
  always #25 clk = !clk;
  lsc_link_ctrl dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_slot(tx_slot),
    .tx_slot_sa(sa), .tx_slot_dl(1'b1), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .rx_slot(rx_slot), .rx_slot_sa(sa), .rx_slot_dl(1'b1), .rx_bit(rx_bit));
  lsc_framer_model fm_u (.clk(clk), .nrst(nrst), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .tx_slot(tx_slot), .rx_slot(rx_slot), .rx_bit(rx_bit));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic poll(input logic [15:0] m, input logic [15:0] v);
    int i;
    for (i = 0; i < 900; i++)
    begin
      rd(4'h5);
      if ((d & m) === v)
        break;
    end
    chk("status", v, d & m);
  endtask
  task automatic frame(input logic [23:0] f);
    int i;
    for (i = 0; i < 3; i++)
      wr(4'h3, {8'h00, f[8*i +: 8]});
    wr(4'h2, 16'h0005);
    poll(16'h0010, 16'h0000);
  endtask
  task automatic drain;
    poll(16'hFF00, {8'(exp_q.size()), 8'h00});
    while (exp_q.size() > 0)
    begin
      rd(4'h4);
      chk("rx fifo", {8'h00, exp_q.pop_front()}, d);
    end
  endtask
  task automatic gbit;
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (tx_bit_valid === 1'b1)
        break;
    end
    bt = tx_bit;
  endtask
  always @(posedge clk)
    if (tx_bit_valid)
    begin
      run = (tx_bit && mon_on) ? run + 1 : 0;
      if (run > 6)
        chk("ones run", 16'h0006, 16'(run));
    end
  initial
  begin
    int i;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      rd(ra[i]);
      chk("reset value", (i == 4) ? 16'h0008 : 16'h0000, d);
    end
    $display("test reset done");
    wr(4'h7, 16'h0303);
    wr(4'h0, 16'h0090);
    rd(4'h0);
    chk("control", 16'h0090, d);
    poll(16'h0020, 16'h0020);
    frame(24'hFF7E03);
    exp_q = '{8'h42, 8'h7E, 8'hFF, 8'h80};
    drain;
    poll(16'h0020, 16'h0020);
    wr(4'h6, 16'h2211);
    wr(4'h7, 16'h4433);
    wr(4'h8, 16'h005A);
    wr(4'h0, 16'h0340);
    exp_q = '{8'h42};
    drain;
    $display("test message done");
    for (i = 0; i < 4; i++)
    begin
      frame({i[7:0], i[1] ? 8'h44 : 8'h33, i[0] ? 8'h22 : 8'h11});
      mon_on = 1'b1;
      exp_q.push_back(i[7:0]);
      exp_q.push_back(8'h80);
    end
    frame(24'hFF5511);
    drain;
    mon_on = 1'b0;
    $display("test address done");
    wr(4'h0, 16'h0001);
    for (i = 0; i < 16; i++)
      gbit;
    wr(4'h3, 16'h000F);
    wr(4'h2, 16'h0022);
    for (i = 0; i < 200 && bt; i++)
      gbit;
    for (i = 5; i < 21; i++)
    begin
      gbit;
      chk("cyclic bit", {15'h0000, !i[2]}, {15'h0000, bt});
    end
    wr(4'h2, 16'h0010);
    rd(4'h5);
    chk("soft reset", 16'h0000, d & 16'hFF10);
    for (i = 0; i < 16; i++)
    begin
      gbit;
      chk("ones", 16'h0001, {15'h0000, bt});
    end
    wr(4'h1, 16'h0005);
    @(posedge clk);
    gbit;
    chk("unselected slot", 16'h0000, {15'h0000, tx_bit_valid});
    sa <= 3'h1;
    gbit;
    chk("selected slot", 16'h0001, {15'h0000, tx_bit_valid});
    $display("test transparent done");
    conclude;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    conclude;
  end
endmodule // lsc_link_ctrl_tb
